// ---- logic/nand_status_pkg.sv ----
// Package with constants and types for the serial NAND status and flag register bank
// Function
// - Failed page program sets program fail flag
// - Program to protected region sets program fail
// - Program execute or reset clears program fail
// - Failed or locked erase sets erase fail
// - Erase start or reset clears erase fail
// - Write enable sets latch, disable clears it
// - Busy flag high during program/read/erase/reset
// - Busy flag low means interface ready
// - Drive strength resets 00b, survives soft reset
// - Block lock bit resets 1, survives soft reset
// - Status and block status are read only
// - Drive codes: full, 75%, 50%, 25%
package nand_status_pkg;

  // Clock and soft reset busy time
  localparam int CLK_PERIOD_NS = 50;
  localparam int SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_COUNT_W = 8;

  // Avalon byte addresses
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
  localparam logic [7:0] ADDR_STATUS = 8'hc0;
  localparam logic [7:0] ADDR_DRIVE = 8'hd0;
  localparam logic [7:0] ADDR_BLOCK = 8'hf0;

  // Field positions
  localparam int STATUS_OIP_BIT = 0;
  localparam int STATUS_WEL_BIT = 1;
  localparam int STATUS_EFAIL_BIT = 2;
  localparam int STATUS_PFAIL_BIT = 3;
  localparam int DRIVE_LO_BIT = 5;
  localparam int DRIVE_HI_BIT = 6;
  localparam int BLOCK_LOCK_BIT = 3;
  localparam int IRQ_PFAIL_BIT = 0;
  localparam int IRQ_EFAIL_BIT = 1;
  localparam int IRQ_DONE_BIT = 2;
  localparam int IRQ_WIDTH = 3;

  // Reset values
  localparam logic [1:0] DRIVE_RESET = 2'h0;
  localparam logic BLOCK_LOCK_RESET = 1'b1;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;

  // Opcodes seen on the serial link
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PROGRAM_EXEC = 8'h10;
  localparam logic [7:0] OP_PAGE_READ = 8'h13;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_SOFT_RESET = 8'hff;

  // Output drive strength encoding
  typedef enum logic [1:0] {
    DRIVE_FULL = 2'h0,
    DRIVE_75 = 2'h1,
    DRIVE_50 = 2'h2,
    DRIVE_25 = 2'h3
  } drive_strength_t;

  // Operation handed to the array core
  typedef enum logic [1:0] {
    KIND_PROGRAM = 2'h0,
    KIND_READ = 2'h1,
    KIND_ERASE = 2'h2
  } core_kind_t;

  // Operation sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROGRAM,
    ST_READ,
    ST_ERASE,
    ST_RESETTING
  } op_state_t;

  // One received opcode
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } opcode_t;

endpackage : nand_status_pkg

// ---- logic/nand_opcode_receiver.sv ----
// Serial link opcode receiver sampled by the system clock
`timescale 1ns/1ps
`default_nettype none
module nand_opcode_receiver (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output nand_status_pkg::opcode_t opcode
);

  // Synchroniser stages; stage one feeds only stage two
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic sck_prev;
  logic [2:0] bit_count;
  logic [6:0] shift;
  logic done;
  logic sck_rise;

  // Two flops on every pin: the link clock is asynchronous to clk
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      sck_prev <= 1'b1;
    end else begin
      sync1 <= {spi_cs_n, spi_sck, spi_mosi};
      sync2 <= sync1;
      sck_prev <= sync2[1];
    end
  end

  // Rising edge of the synchronised link clock
  assign sck_rise = sync2[1] & ~sck_prev;

  // Shift in the first byte of each frame, MSB first; later bytes are ignored
  always_ff @(posedge clk) begin
    if (rst || sync2[2]) begin
      bit_count <= 3'h0;
      shift <= 7'h0;
      done <= 1'b0;
      opcode <= '0;
    end else begin
      opcode.valid <= 1'b0;
      if (sck_rise && !done) begin
        shift <= {shift[5:0], sync2[0]};
        bit_count <= bit_count + 3'h1;
        if (bit_count == 3'h7) begin
          done <= 1'b1;
          opcode.valid <= 1'b1;
          opcode.code <= {shift, sync2[0]};
        end
      end
    end
  end

endmodule : nand_opcode_receiver
`default_nettype wire

// ---- logic/nand_status_flag_logic.sv ----
// Status, flag and driver register bank of the serial NAND device
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module nand_status_flag_logic (
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial link pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  // Array core, same clock
  input wire logic target_locked,
  input wire logic block_lock_sense,
  input wire logic core_done,
  input wire logic core_fail,
  output logic core_start,
  output nand_status_pkg::core_kind_t core_kind,
  // Pad control and status
  output nand_status_pkg::drive_strength_t drive_strength,
  output logic operation_in_progress,
  output logic irq
);

  // Received opcode
  nand_status_pkg::opcode_t opcode;
  // Sequencer state
  nand_status_pkg::op_state_t state;
  nand_status_pkg::op_state_t next_state;
  // Soft reset busy counter
  logic [nand_status_pkg::RESET_COUNT_W-1:0] reset_count;
  // Flags
  logic program_fail;
  logic erase_fail;
  logic write_enable_latch;
  logic selected_block_locked;
  // Interrupt registers
  logic [nand_status_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [nand_status_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic [nand_status_pkg::IRQ_WIDTH-1:0] irq_events;
  logic [nand_status_pkg::IRQ_WIDTH-1:0] next_irq_status;
  // Decoded commands and flag events
  logic cmd_program;
  logic cmd_erase;
  logic cmd_read;
  logic cmd_reset;
  logic pfail_set;
  logic efail_set;
  logic op_finished;
  logic bus_write;

  // Opcode receiver on the link side
  nand_opcode_receiver u_rx (
    .clk(clk),
    .rst(rst),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .opcode(opcode)
  );

  // True when a valid opcode equals the given code
  function automatic logic is_op(input nand_status_pkg::opcode_t op, input logic [7:0] code);
    is_op = op.valid && (op.code == code);
  endfunction : is_op

  // Command decode; array commands only start while idle
  assign cmd_program = (state == nand_status_pkg::ST_IDLE) && is_op(opcode, nand_status_pkg::OP_PROGRAM_EXEC);
  assign cmd_erase = (state == nand_status_pkg::ST_IDLE) && is_op(opcode, nand_status_pkg::OP_BLOCK_ERASE);
  assign cmd_read = (state == nand_status_pkg::ST_IDLE) && is_op(opcode, nand_status_pkg::OP_PAGE_READ);
  // Reset is honoured at any time, even mid-operation
  assign cmd_reset = is_op(opcode, nand_status_pkg::OP_SOFT_RESET);

  // Locked target fails at once; array failure is reported on completion
  assign pfail_set = (cmd_program && target_locked) ||
                     (state == nand_status_pkg::ST_PROGRAM && core_done && core_fail && !cmd_reset);
  assign efail_set = (cmd_erase && target_locked) ||
                     (state == nand_status_pkg::ST_ERASE && core_done && core_fail && !cmd_reset);

  // Next sequencer state
  always_comb begin
    next_state = state;
    case (state)
      nand_status_pkg::ST_IDLE: begin
        if (cmd_reset) begin
          next_state = nand_status_pkg::ST_RESETTING;
        end else if (cmd_program && !target_locked) begin
          next_state = nand_status_pkg::ST_PROGRAM; // Locked target stays idle, busy never rises
        end else if (cmd_erase && !target_locked) begin
          next_state = nand_status_pkg::ST_ERASE;
        end else if (cmd_read) begin
          next_state = nand_status_pkg::ST_READ;
        end
      end
      nand_status_pkg::ST_PROGRAM, nand_status_pkg::ST_READ, nand_status_pkg::ST_ERASE: begin
        if (cmd_reset) begin
          next_state = nand_status_pkg::ST_RESETTING;
        end else if (core_done) begin
          next_state = nand_status_pkg::ST_IDLE;
        end
      end
      nand_status_pkg::ST_RESETTING: begin
        if (reset_count == '0) begin
          next_state = nand_status_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = nand_status_pkg::ST_IDLE;
      end
    endcase
  end

  // State register and busy flag, registered from the same next value
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= nand_status_pkg::ST_IDLE;
      operation_in_progress <= 1'b0;
    end else begin
      state <= next_state;
      operation_in_progress <= (next_state != nand_status_pkg::ST_IDLE);
    end
  end

  // Busy time of a soft reset; restarts if another reset arrives
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_count <= '0;
    end else if (cmd_reset) begin
      reset_count <= nand_status_pkg::RESET_COUNT_W'(nand_status_pkg::SOFT_RESET_CYCLES - 1);
    end else if (reset_count != '0) begin
      reset_count <= reset_count - 1'b1;
    end
  end

  // Start pulse and kind to the array core
  always_ff @(posedge clk) begin
    if (rst) begin
      core_start <= 1'b0;
      core_kind <= nand_status_pkg::KIND_PROGRAM;
    end else begin
      core_start <= (state == nand_status_pkg::ST_IDLE) &&
                    (next_state != nand_status_pkg::ST_IDLE) &&
                    (next_state != nand_status_pkg::ST_RESETTING);
      if (next_state == nand_status_pkg::ST_ERASE) begin
        core_kind <= nand_status_pkg::KIND_ERASE;
      end else if (next_state == nand_status_pkg::ST_READ) begin
        core_kind <= nand_status_pkg::KIND_READ;
      end else if (next_state == nand_status_pkg::ST_PROGRAM) begin
        core_kind <= nand_status_pkg::KIND_PROGRAM;
      end
    end
  end

  // Program fail: set wins over the clear of the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      program_fail <= 1'b0;
    end else if (pfail_set) begin
      program_fail <= 1'b1;
    end else if (cmd_program || cmd_reset) begin
      program_fail <= 1'b0;
    end
  end

  // Erase fail: cleared as the erase sequence starts
  always_ff @(posedge clk) begin
    if (rst) begin
      erase_fail <= 1'b0;
    end else if (efail_set) begin
      erase_fail <= 1'b1;
    end else if (cmd_erase || cmd_reset) begin
      erase_fail <= 1'b0;
    end
  end

  // Write enable latch; the host must see it set before program or erase
  always_ff @(posedge clk) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (is_op(opcode, nand_status_pkg::OP_WRITE_ENABLE)) begin
      write_enable_latch <= 1'b1;
    end else if (is_op(opcode, nand_status_pkg::OP_WRITE_DISABLE) || cmd_reset) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Block lock status follows the protection logic; only power-up reset forces it
  always_ff @(posedge clk) begin
    if (rst) begin
      selected_block_locked <= nand_status_pkg::BLOCK_LOCK_RESET;
    end else begin
      selected_block_locked <= block_lock_sense;
    end
  end

  // A write is taken only at the edge where waitrequest is low
  assign bus_write = write && !waitrequest;

  // Drive strength: bus writes and power-up reset change it, soft reset does not
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_strength <= nand_status_pkg::drive_strength_t'(nand_status_pkg::DRIVE_RESET);
    end else if (bus_write && address == nand_status_pkg::ADDR_DRIVE) begin
      drive_strength <= nand_status_pkg::drive_strength_t'(
        writedata[nand_status_pkg::DRIVE_HI_BIT:nand_status_pkg::DRIVE_LO_BIT]);
    end
  end

  // Interrupt events
  assign op_finished = (state != nand_status_pkg::ST_IDLE) && (next_state == nand_status_pkg::ST_IDLE);
  always_comb begin
    irq_events = '0;
    irq_events[nand_status_pkg::IRQ_PFAIL_BIT] = pfail_set;
    irq_events[nand_status_pkg::IRQ_EFAIL_BIT] = efail_set;
    irq_events[nand_status_pkg::IRQ_DONE_BIT] = op_finished;
    next_irq_status = irq_status;
    if (bus_write && address == nand_status_pkg::ADDR_IRQ_STATUS) begin
      next_irq_status = irq_status & ~writedata[nand_status_pkg::IRQ_WIDTH-1:0];
    end
    // New events win over a write-one-to-clear in the same cycle
    next_irq_status = next_irq_status | irq_events;
  end

  // Sticky status, mask and the level interrupt output
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= '0;
      irq_mask <= nand_status_pkg::IRQ_MASK_RESET;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (bus_write && address == nand_status_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= writedata[nand_status_pkg::IRQ_WIDTH-1:0];
        irq <= |(next_irq_status & writedata[nand_status_pkg::IRQ_WIDTH-1:0]);
      end else begin
        irq <= |(next_irq_status & irq_mask);
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  function automatic logic [31:0] read_value(input logic [7:0] addr);
    read_value = '0;
    case (addr)
      nand_status_pkg::ADDR_STATUS: begin
        read_value[nand_status_pkg::STATUS_OIP_BIT] = operation_in_progress;
        read_value[nand_status_pkg::STATUS_WEL_BIT] = write_enable_latch;
        read_value[nand_status_pkg::STATUS_EFAIL_BIT] = erase_fail;
        read_value[nand_status_pkg::STATUS_PFAIL_BIT] = program_fail;
      end
      nand_status_pkg::ADDR_DRIVE: begin
        read_value[nand_status_pkg::DRIVE_HI_BIT:nand_status_pkg::DRIVE_LO_BIT] = drive_strength;
      end
      nand_status_pkg::ADDR_BLOCK: begin
        read_value[nand_status_pkg::BLOCK_LOCK_BIT] = selected_block_locked;
      end
      nand_status_pkg::ADDR_IRQ_STATUS: begin
        read_value[nand_status_pkg::IRQ_WIDTH-1:0] = irq_status;
      end
      nand_status_pkg::ADDR_IRQ_MASK: begin
        read_value[nand_status_pkg::IRQ_WIDTH-1:0] = irq_mask;
      end
      default: begin
        read_value = '0;
      end
    endcase
  endfunction : read_value

  // One wait cycle per access; status and block addresses ignore writes
  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= '0;
    end else if (waitrequest && (read || write)) begin
      waitrequest <= 1'b0;
      readdata <= read ? read_value(address) : 32'h0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // Checks
  default clocking chk_clk @(posedge clk); endclocking
  default disable iff (rst);

  pfail_core_a: assert property (state == nand_status_pkg::ST_PROGRAM && core_done && core_fail && !cmd_reset
    |=> program_fail && !operation_in_progress) else $error("program fail not set");
  pfail_lock_a: assert property (cmd_program && target_locked
    |=> program_fail && !operation_in_progress && !core_start) else $error("locked program not flagged");
  pfail_clear_a: assert property (cmd_program && !target_locked
    |=> !program_fail && operation_in_progress) else $error("program fail not cleared");
  efail_set_a: assert property (efail_set |=> erase_fail) else $error("erase fail not set");
  efail_clear_a: assert property (cmd_erase && !target_locked |=> !erase_fail ##1 core_kind == nand_status_pkg::KIND_ERASE)
    else $error("erase fail not cleared");
  wel_cmds_a: assert property (is_op(opcode, nand_status_pkg::OP_WRITE_DISABLE) |=> !write_enable_latch)
    else $error("write disable ignored");
  busy_reset_a: assert property (cmd_reset |=> operation_in_progress [*8]) else $error("busy dropped during reset");
  soft_reset_a: assert property (cmd_reset && !(bus_write && address == nand_status_pkg::ADDR_DRIVE)
    |=> !program_fail && !erase_fail && !write_enable_latch && $stable(drive_strength))
    else $error("soft reset effect wrong");
  status_ro_a: assert property (bus_write && address == nand_status_pkg::ADDR_STATUS && opcode == '0 && !core_done
    |=> $stable(program_fail) && $stable(erase_fail) && $stable(write_enable_latch)) else $error("status written");
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");

  program_fail_c: cover property (state == nand_status_pkg::ST_PROGRAM && core_done && core_fail);
  erase_done_c: cover property (state == nand_status_pkg::ST_ERASE ##[1:100] op_finished);
  reset_busy_c: cover property (cmd_reset ##[1:40] !operation_in_progress);

endmodule : nand_status_flag_logic
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// Behavioural host link controller that frames one opcode per request
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic send,
  input wire logic [7:0] op,
  output logic busy,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi
);
  // Link clock stands low and select high outside frames, 400 ns period inside
  initial begin
    busy = 1'b0;
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    forever begin
      wait (send === 1'b1);
      busy = 1'b1;
      spi_cs_n = 1'b0;
      // Select setup time; it also lets the opcode input settle before its first bit is read
      #200;
      // Eight bits, most significant first, sampled by the device on the rise
      for (int i = 7; i >= 0; i--) begin
        spi_mosi = op[i];
        #200 spi_sck = 1'b1;
        #200 spi_sck = 1'b0;
      end
      #200 spi_cs_n = 1'b1;
      // Released data line shows the inverse, so a stale bit is never trusted
      spi_mosi = ~spi_mosi;
      #400 busy = 1'b0;
      wait (send === 1'b0);
    end
  end
endmodule : spi_host_model
`default_nettype wire

// ---- dv/tb_nand_status_flag_logic.sv ----
// Self-checking bench for the status and flag register bank
`timescale 1ns/1ps
`default_nettype none
`define check_eq(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_nand_status_flag_logic;
  logic clk, rst, read, write, waitrequest, spi_sck, spi_cs_n, spi_mosi; // Bus and link
  logic [7:0] address; // Byte address
  logic [31:0] writedata, readdata, d; // Bus data and last read
  logic target_locked, block_lock_sense, core_done, core_fail, core_start; // Array core side
  logic operation_in_progress, irq, send, host_busy, fail_next; // Status and host
  logic [7:0] sop, cnt; // Opcode to send, core latency count
  nand_status_pkg::core_kind_t core_kind, exp_kind; // Issued and expected operation
  nand_status_pkg::drive_strength_t drive_strength; // Pad drive code
  int n_fail, total_checks, seed, busy_base; // Counters, seed, busy count at frame start
  int busy_cnt = 0; // Busy cycles seen; only the monitor writes it
  logic pf, ef, fl, lk; // Expected fail flags, drawn fail, locked target
  logic [1:0] dv; // Drive code kept across soft reset
  logic [7:0] o; // Current opcode
  nand_status_flag_logic i_nand_status_flag_logic (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .target_locked(target_locked), .block_lock_sense(block_lock_sense),
    .core_done(core_done), .core_fail(core_fail), .core_start(core_start), .core_kind(core_kind),
    .drive_strength(drive_strength), .operation_in_progress(operation_in_progress), .irq(irq));
  spi_host_model i_spi_host_model (.send(send), .op(sop), .busy(host_busy), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Array core stand-in: random latency, result chosen by the scenario
  always @(posedge clk) begin
    core_done <= 1'b0;
    core_fail <= 1'b0;
    if (rst) cnt <= 8'h0;
    else if (core_start === 1'b1) cnt <= 8'h3 + 8'($unsigned($random(seed)) % 8);
    else if (cnt != 8'h0) begin
      cnt <= cnt - 8'h1;
      if (cnt == 8'h1) begin
        core_done <= 1'b1;
        core_fail <= fail_next;
      end
    end
  end
  // Busy monitor and operation kind check
  always @(posedge clk) begin
    if (operation_in_progress === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end
    if (core_start === 1'b1) `check_eq(core_kind, exp_kind)
  end
  // Verdict and end of run
  task automatic end_of_test;
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk);
    address <= a;
    read <= ~we;
    write <= we;
    writedata <= wd;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      n_fail++;
      end_of_test();
    end
  endtask : bus
  // Send one opcode frame and note the busy monitor count at its start
  task automatic op_send(input logic [7:0] c);
    int i;
    @(posedge clk);
    sop <= c;
    send <= 1'b1;
    busy_base = busy_cnt;
    for (i = 0; i < 20 && host_busy !== 1'b1; i++) @(posedge clk);
    if (i == 20) begin
      n_fail++;
      end_of_test();
    end
    send <= 1'b0;
    for (i = 0; i < 200 && host_busy !== 1'b0; i++) @(posedge clk);
    if (i == 200) begin
      n_fail++;
      end_of_test();
    end
  endtask : op_send
  // Ready is taken from the busy flag going low
  task automatic wait_idle;
    int i;
    for (i = 0; i < 400 && operation_in_progress !== 1'b0; i++) @(posedge clk);
    if (i == 400) begin
      n_fail++;
      end_of_test();
    end
    repeat (2) @(posedge clk);
  endtask : wait_idle
  // Expected status word
  function automatic logic [31:0] st(input logic p, e, w, b);
    st = 32'h0;
    st[nand_status_pkg::STATUS_PFAIL_BIT] = p;
    st[nand_status_pkg::STATUS_EFAIL_BIT] = e;
    st[nand_status_pkg::STATUS_WEL_BIT] = w;
    st[nand_status_pkg::STATUS_OIP_BIT] = b;
  endfunction : st
  // Expected block status word
  function automatic logic [31:0] blk(input logic v);
    blk = 32'h0;
    blk[nand_status_pkg::BLOCK_LOCK_BIT] = v;
  endfunction : blk
  // Main sequence
  initial begin
    n_fail = 0;
    total_checks = 0;
    seed = 5;
    rst = 1'b1;
    {read, write, send, target_locked, fail_next} = '0;
    address = 8'h0;
    writedata = 32'h0;
    sop = 8'h0;
    exp_kind = nand_status_pkg::KIND_PROGRAM;
    block_lock_sense = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, nand_status_pkg::ADDR_STATUS, 32'h0, d); `check_eq(d, st(0, 0, 0, 0))
    bus(1'b0, nand_status_pkg::ADDR_BLOCK, 32'h0, d); `check_eq(d, blk(1'b1))
    bus(1'b0, nand_status_pkg::ADDR_DRIVE, 32'h0, d); `check_eq(d, 32'h0)
    // Writes to read-only and unmapped places change nothing
    bus(1'b1, nand_status_pkg::ADDR_STATUS, 32'hffffffff, d);
    bus(1'b1, nand_status_pkg::ADDR_BLOCK, 32'h0, d);
    bus(1'b1, 8'h80, 32'hffffffff, d);
    bus(1'b0, nand_status_pkg::ADDR_STATUS, 32'h0, d); `check_eq(d, st(0, 0, 0, 0))
    bus(1'b0, nand_status_pkg::ADDR_BLOCK, 32'h0, d); `check_eq(d, blk(1'b1))
    bus(1'b0, 8'h80, 32'h0, d); `check_eq(d, 32'h0)
    block_lock_sense <= 1'b0;
    bus(1'b0, nand_status_pkg::ADDR_BLOCK, 32'h0, d); `check_eq(d, blk(1'b0))
    // Every drive code, then a random one kept for the soft reset
    for (int i = 0; i < 5; i++) begin
      dv = (i < 4) ? 2'(i) : 2'($random(seed));
      bus(1'b1, nand_status_pkg::ADDR_DRIVE, {25'h0, dv, 5'h0}, d);
      bus(1'b0, nand_status_pkg::ADDR_DRIVE, 32'h0, d); `check_eq(d, {25'h0, dv, 5'h0})
      `check_eq(drive_strength, nand_status_pkg::drive_strength_t'(dv))
    end
    op_send(nand_status_pkg::OP_WRITE_ENABLE);
    bus(1'b0, nand_status_pkg::ADDR_STATUS, 32'h0, d); `check_eq(d, st(0, 0, 1, 0))
    op_send(nand_status_pkg::OP_WRITE_DISABLE);
    bus(1'b0, nand_status_pkg::ADDR_STATUS, 32'h0, d); `check_eq(d, st(0, 0, 0, 0))
    // Program, erase and read: failing, passing, then locked; reads always pass
    pf = 1'b0;
    ef = 1'b0;
    for (int k = 0; k < 9; k++) begin
      o = (k % 3 == 0) ? nand_status_pkg::OP_PROGRAM_EXEC :
          (k % 3 == 1) ? nand_status_pkg::OP_BLOCK_ERASE : nand_status_pkg::OP_PAGE_READ;
      fl = (k < 3) ? 1'b1 : (k < 6) ? 1'b0 : 1'($random(seed));
      if (o == nand_status_pkg::OP_PAGE_READ) fl = 1'b0;
      lk = (k >= 6) && (o != nand_status_pkg::OP_PAGE_READ);
      exp_kind = (k % 3 == 0) ? nand_status_pkg::KIND_PROGRAM :
                 (k % 3 == 1) ? nand_status_pkg::KIND_ERASE : nand_status_pkg::KIND_READ;
      op_send(nand_status_pkg::OP_WRITE_ENABLE);
      bus(1'b0, nand_status_pkg::ADDR_STATUS, 32'h0, d);
      `check_eq(d[nand_status_pkg::STATUS_WEL_BIT], 1'b1)
      fail_next <= fl;
      target_locked <= lk;
      op_send(o);
      wait_idle();
      `check_eq(busy_cnt != busy_base, ~lk)
      if (k % 3 == 0) pf = fl | lk;
      if (k % 3 == 1) ef = fl | lk;
      bus(1'b0, nand_status_pkg::ADDR_STATUS, 32'h0, d); `check_eq(d, st(pf, ef, 1, 0))
    end
    // Interrupt: clear, masked event, unmask, clear by writing one
    target_locked <= 1'b0;
    bus(1'b1, nand_status_pkg::ADDR_IRQ_STATUS, 32'h7, d);
    fail_next <= 1'b1;
    exp_kind = nand_status_pkg::KIND_PROGRAM;
    op_send(nand_status_pkg::OP_PROGRAM_EXEC);
    wait_idle();
    `check_eq(irq, 1'b0)
    bus(1'b0, nand_status_pkg::ADDR_IRQ_STATUS, 32'h0, d); `check_eq(d, 32'h5)
    bus(1'b1, nand_status_pkg::ADDR_IRQ_MASK, 32'h1, d);
    repeat (2) @(posedge clk);
    `check_eq(irq, 1'b1)
    bus(1'b1, nand_status_pkg::ADDR_IRQ_STATUS, 32'h1, d);
    repeat (2) @(posedge clk);
    `check_eq(irq, 1'b0)
    // Soft reset clears flags and latch, keeps drive and block status
    op_send(nand_status_pkg::OP_SOFT_RESET);
    wait_idle();
    `check_eq(busy_cnt - busy_base, nand_status_pkg::SOFT_RESET_CYCLES)
    bus(1'b0, nand_status_pkg::ADDR_STATUS, 32'h0, d); `check_eq(d, st(0, 0, 0, 0))
    bus(1'b0, nand_status_pkg::ADDR_DRIVE, 32'h0, d); `check_eq(d, {25'h0, dv, 5'h0})
    bus(1'b0, nand_status_pkg::ADDR_BLOCK, 32'h0, d); `check_eq(d, blk(1'b0))
    // Power-up reset in mid-run brings a changed drive code back to full strength
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, nand_status_pkg::ADDR_DRIVE, 32'h0, d); `check_eq(d, 32'h0)
    bus(1'b0, nand_status_pkg::ADDR_STATUS, 32'h0, d); `check_eq(d, st(0, 0, 0, 0))
    end_of_test();
  end
endmodule : tb_nand_status_flag_logic
`default_nettype wire
